// File: adc_seq_pkg.sv
/*
  Package for the conversion sequencer: register map, field positions,
  reset values, channel codes, sequencer states and timing counts.
  Assumes a 40 MHz APB clock; the conversion tick divides it by eight.
*/
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned TICK_DIV        = 8;
  localparam int unsigned SETTLE_TICKS    = 16;
  localparam int unsigned RES_MIN         = 7;
  localparam int unsigned RES_MAX         = 12;
  localparam int unsigned CNT_W           = RES_MAX + 1;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFF        = 8'h00;
  localparam logic [7:0]  STATUS_OFF      = 8'h04;
  localparam logic [7:0]  CFG_OFF         = 8'h08;
  localparam logic [7:0]  RESULT_OFF      = 8'h0c;

  // CTRL: write 1 to start a sequence
  localparam int unsigned CTRL_START_BIT  = 0;
  // STATUS: busy, current channel
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_CHAN_LSB   = 4;
  // CFG: channel enables, differential pair, resolution
  localparam int unsigned CFG_EN_LSB      = 0;
  localparam int unsigned CFG_DIFF_BIT    = 4;
  localparam int unsigned CFG_RES_LSB     = 8;
  // RESULT: sign-extended value, channel of that value
  localparam int unsigned RES_CHAN_LSB    = 16;

  localparam logic [3:0]  CFG_EN_RST      = 4'h1;
  localparam logic [3:0]  CFG_RES_RST     = 4'hc;

  // ----------------------------------------------------------------
  // Input multiplexer codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  CH_AIN0         = 2'h0;
  localparam logic [1:0]  CH_AIN1         = 2'h1;
  localparam logic [1:0]  CH_TEMP         = 2'h2;
  localparam logic [1:0]  CH_SUPPLY3      = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SELECT = 5'b00010,
    ST_SETTLE = 5'b00100,
    ST_DECIM  = 5'b01000,
    ST_DONE   = 5'b10000
  } seq_state_e;

endpackage

// File: adc_conversion_sequencer.sv
/*
  Conversion sequencer for the on-chip converter: APB register slave,
  divide-by-eight conversion tick, channel stepping, settling wait,
  decimation of the modulator bit stream and signed result formatting.
  Assumes the front end delivers one modulator bit per tick on mod_bit,
  synchronous to pclk, and follows mux_sel/diff_mode/ref_internal.
*/
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        converter_read_command,
  input  wire logic        mod_bit,
  output logic [1:0]       mux_sel,
  output logic             diff_mode,
  output logic             ref_internal,
  output logic             mod_enable,
  output logic             busy,
  output logic             result_valid,
  output logic [1:0]       result_chan,
  output logic [15:0]      result_data
);

  localparam int unsigned DW = $clog2(DIV);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] first_set(input logic [3:0] m);
    first_set = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction

  function automatic logic [CNT_W-1:0] rate_of(input logic [3:0] res);
    rate_of = CNT_W'(1) << res;
  endfunction

  // Bipolar modulator: ones count c out of n; full-scale ones clamp to max
  function automatic logic [15:0] format_result(input logic [CNT_W-1:0] c,
                                                input logic [3:0] res,
                                                input logic dif);
    logic [CNT_W-1:0] n;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] v;
    n    = rate_of(res);
    half = n >> 1;
    if (dif) begin
      v = (c == n) ? half - CNT_W'(1) : c - half;
      format_result = {{(16-CNT_W){v[CNT_W-1]}}, v};
    end else begin
      v = (c == n) ? half - CNT_W'(1) : c >> 1;
      format_result = {{(16-CNT_W){1'b0}}, v};
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  seq_state_e        st_q, st_d;
  logic [DW-1:0]     div_q;
  logic              tick_q;
  logic [3:0]        en_q;
  logic              diff_q;
  logic [3:0]        res_q;
  logic [3:0]        pend_q;
  logic [1:0]        chan_q;
  logic [2:0]        last_chan_q;
  logic [4:0]        settle_q;
  logic [CNT_W-1:0]  decim_q;
  logic [CNT_W-1:0]  ones_q;
  logic [3:0]        run_res_q;
  logic              run_diff_q;
  logic [15:0]       last_result_q;
  logic [1:0]        last_rchan_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              valid_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire        setup    = psel & ~penable;
  wire        wr_acc   = psel & penable & pwrite & pready_q;
  wire        hit_ctrl = (paddr == CTRL_OFF);
  wire        hit_stat = (paddr == STATUS_OFF);
  wire        hit_cfg  = (paddr == CFG_OFF);
  wire        hit_res  = (paddr == RESULT_OFF);
  wire        mapped   = hit_ctrl | hit_stat | hit_cfg | hit_res;
  wire [3:0]  wr_res   = pwdata[CFG_RES_LSB +: 4];
  // Out-of-range resolutions clamp rather than fault
  wire [3:0]  res_clip = (wr_res < 4'(RES_MIN)) ? 4'(RES_MIN) :
                         (wr_res > 4'(RES_MAX)) ? 4'(RES_MAX) : wr_res;
  wire        start    = converter_read_command |
                         (wr_acc & hit_ctrl & pwdata[CTRL_START_BIT]);
  wire        busy_w   = (st_q != ST_IDLE);
  wire [31:0] rd_mux   = hit_stat ? {26'h0, chan_q, 3'h0, busy_w} :
                         hit_cfg  ? {20'h0, res_q, 3'h0, diff_q, en_q} :
                         hit_res  ? {14'h0, last_rchan_q, last_result_q} :
                         32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // Configuration is frozen while a sequence runs via run_* copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q   <= CFG_EN_RST;
      diff_q <= 1'b0;
      res_q  <= CFG_RES_RST;
    end else if (wr_acc & hit_cfg) begin
      en_q   <= pwdata[CFG_EN_LSB +: 4];
      diff_q <= pwdata[CFG_DIFF_BIT];
      res_q  <= res_clip;
    end
  end

  // ----------------------------------------------------------------
  // Conversion tick
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= (div_q == DW'(DIV - 1)) ? '0 : div_q + DW'(1);
      tick_q <= (div_q == DW'(DIV - 1));
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // In differential mode input one is folded into the pair on channel 0
  wire [3:0] seq_mask = diff_q ? (en_q & 4'hd) | {3'h0, en_q[1]} : en_q;
  wire [1:0] next_ch  = first_set(pend_q);
  wire       changed  = (last_chan_q != {1'b0, next_ch});
  wire       settle_end = tick_q & (settle_q == 5'(SETTLE_TICKS - 1));
  wire       decim_end  = tick_q & (decim_q == rate_of(run_res_q) - CNT_W'(1));

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:   if (start && seq_mask != 4'h0) st_d = ST_SELECT;
      ST_SELECT: st_d = changed ? ST_SETTLE : ST_DECIM;
      ST_SETTLE: if (settle_end) st_d = ST_DECIM;
      ST_DECIM:  if (decim_end) st_d = ST_DONE;
      ST_DONE:   st_d = (pend_q == 4'h0) ? ST_IDLE : ST_SELECT;
      default:   st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= ST_IDLE;
      pend_q      <= 4'h0;
      chan_q      <= CH_AIN0;
      last_chan_q <= 3'h4;
      settle_q    <= 5'h0;
      decim_q     <= '0;
      ones_q      <= '0;
      run_res_q   <= CFG_RES_RST;
      run_diff_q  <= 1'b0;
    end else begin
      st_q <= st_d;
      // Starts are only seen in idle, so a command mid-sequence is dropped
      if (st_q == ST_IDLE && start) begin
        pend_q     <= seq_mask;
        run_res_q  <= res_q;
        run_diff_q <= diff_q;
      end
      if (st_q == ST_SELECT) begin
        chan_q      <= next_ch;
        pend_q      <= pend_q & ~(4'h1 << next_ch);
        last_chan_q <= {1'b0, next_ch};
        settle_q    <= 5'h0;
        decim_q     <= '0;
        ones_q      <= '0;
      end
      if (st_q == ST_SETTLE && tick_q) begin
        settle_q <= settle_q + 5'h1;
      end
      if (st_q == ST_DECIM && tick_q) begin
        decim_q <= decim_q + CNT_W'(1);
        ones_q  <= ones_q + CNT_W'(mod_bit);
      end
    end
  end

  // ----------------------------------------------------------------
  // Front-end controls and result outputs
  // ----------------------------------------------------------------
  wire [15:0] fmt_w = format_result(ones_q, run_res_q, run_diff_q & (chan_q == CH_AIN0));

  // Enable follows the next state so the front end is live on the first decimation tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_sel       <= CH_AIN0;
      diff_mode     <= 1'b0;
      ref_internal  <= 1'b1;
      mod_enable    <= 1'b0;
      busy          <= 1'b0;
      valid_q       <= 1'b0;
      result_chan   <= CH_AIN0;
      result_data   <= 16'h0;
      last_result_q <= 16'h0;
      last_rchan_q  <= CH_AIN0;
    end else begin
      mux_sel      <= chan_q;
      diff_mode    <= run_diff_q & (chan_q == CH_AIN0);
      // Only one reference exists; single-ended must never leave it
      ref_internal <= 1'b1;
      mod_enable   <= (st_d == ST_SETTLE) | (st_d == ST_DECIM);
      busy         <= (st_d != ST_IDLE);
      valid_q      <= (st_q == ST_DONE);
      if (st_q == ST_DONE) begin
        result_chan   <= chan_q;
        result_data   <= fmt_w;
        last_result_q <= fmt_w;
        last_rchan_q  <= chan_q;
      end
    end
  end

  assign result_valid = valid_q;
  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] chk_ticks_q;
  logic [1:0]       chk_prev_q;
  logic             chk_seq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_ticks_q <= '0;
      chk_prev_q  <= 2'h0;
      chk_seq_q   <= 1'b0;
    end else begin
      chk_ticks_q <= (st_q != st_d) ? '0 : chk_ticks_q + CNT_W'(tick_q);
      if (valid_q) chk_prev_q <= result_chan;
      if (valid_q) chk_seq_q <= busy;
    end
  end
  wire signed [15:0] chk_val  = result_data;
  wire signed [15:0] chk_half = 16'(rate_of(run_res_q) >> 1);

  sequence s_tick_gap;
    !tick_q [*7] ##1 tick_q;
  endsequence
  property p_tick;
    @(posedge pclk) disable iff (!presetn) tick_q |=> s_tick_gap;
  endproperty
  a_tick: assert property (p_tick) else $error("tick period not eight");
  property p_decim_len;
    @(posedge pclk) disable iff (!presetn)
      (st_q == ST_DECIM && st_d == ST_DONE) |-> chk_ticks_q == rate_of(run_res_q) - CNT_W'(1);
  endproperty
  a_decim_len: assert property (p_decim_len) else $error("decimation length wrong");
  property p_settle_len;
    @(posedge pclk) disable iff (!presetn)
      (st_q == ST_SETTLE && st_d == ST_DECIM) |-> chk_ticks_q == CNT_W'(SETTLE_TICKS - 1);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settling length wrong");
  property p_res_range;
    @(posedge pclk) disable iff (!presetn) res_q >= 4'(RES_MIN) && res_q <= 4'(RES_MAX);
  endproperty
  a_res_range: assert property (p_res_range) else $error("resolution out of range");
  property p_single_pos;
    @(posedge pclk) disable iff (!presetn)
      (valid_q && !diff_mode) |-> !result_data[15] && chk_val < chk_half;
  endproperty
  a_single_pos: assert property (p_single_pos) else $error("single-ended result negative");
  property p_diff_span;
    @(posedge pclk) disable iff (!presetn)
      (valid_q && diff_mode) |-> chk_val >= -chk_half && chk_val < chk_half;
  endproperty
  a_diff_span: assert property (p_diff_span) else $error("differential result out of span");
  property p_ascend;
    @(posedge pclk) disable iff (!presetn)
      (valid_q && chk_seq_q) |-> result_chan > chk_prev_q;
  endproperty
  a_ascend: assert property (p_ascend) else $error("channels not ascending");
  property p_pair;
    @(posedge pclk) disable iff (!presetn) diff_mode |-> mux_sel == CH_AIN0;
  endproperty
  a_pair: assert property (p_pair) else $error("differential not on pair");
  property p_ref;
    @(posedge pclk) disable iff (!presetn) !diff_mode |-> ref_internal;
  endproperty
  a_ref: assert property (p_ref) else $error("single-ended without internal ref");
  property p_strobe;
    @(posedge pclk) disable iff (!presetn)
      valid_q |-> (busy == (st_q == ST_SELECT)) ##1 !valid_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("valid not one-cycle or busy wrong");
  property p_ignore;
    @(posedge pclk) disable iff (!presetn)
      (busy && st_q != ST_SELECT && converter_read_command) |=> $stable(pend_q) &&
      $stable(run_res_q) && $stable(run_diff_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("command disturbed sequence");

endmodule

// File: adc_front_end_model.sv
/*
  Behavioural model of the analog front end: input multiplexer and
  modulator. Each channel is held at either full scale or zero, so
  every modulator bit for that channel equals its level bit.
  Assumes that mod_enable marks when the sequencer listens.
*/
module adc_front_end_model (
  input  wire logic       pclk,
  input  wire logic [1:0] mux_sel,
  input  wire logic       diff_mode,
  input  wire logic       ref_internal,
  input  wire logic       mod_enable,
  input  wire logic [3:0] level,
  output logic            mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Bit stream
  // ----------------------------------------------------------------
  logic idle_q = 1'b0;

  // Toggles when nobody listens, so a stale level cannot pass for data
  always @(posedge pclk) idle_q <= ~idle_q;

  // Pair 0 gives its difference level; the others one pin against ground
  // A single-ended conversion without the internal reference gives garbage
  assign mod_bit = (!mod_enable || (!diff_mode && !ref_internal)) ? idle_q : level[mux_sel];
endmodule

// File: tb_top.sv
/*
  Self-checking bench for the conversion sequencer: APB master tasks,
  a queue model of the expected results and their timing.
  Assumes the front-end model file is compiled before this one.
*/
module tb_top
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        converter_read_command = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, mod_bit, diff_mode, ref_internal, mod_enable;
  logic        busy, result_valid;
  logic [1:0]  mux_sel, result_chan;
  logic [15:0] result_data;
  logic [3:0]  level = '0;
  int          n_errors = 0, n_tests = 0, cyc = 0, res = 12, last = -1, last_exp;
  int          exp_q[$], tq[$];
  bit          dif = 0;
  realtime     t0;

  adc_conversion_sequencer #(.DIV(TICK_DIV)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .converter_read_command(converter_read_command), .mod_bit(mod_bit),
    .mux_sel(mux_sel), .diff_mode(diff_mode), .ref_internal(ref_internal),
    .mod_enable(mod_enable), .busy(busy), .result_valid(result_valid),
    .result_chan(result_chan), .result_data(result_data));

  adc_front_end_model i_fe (.pclk(pclk), .mux_sel(mux_sel), .diff_mode(diff_mode),
    .ref_internal(ref_internal), .mod_enable(mod_enable), .level(level), .mod_bit(mod_bit));

  initial forever #12.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling sits above the longest planned run of about 76k cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      complete_run();
    end
  end

  always @(posedge pclk) if (result_valid === 1'b1) begin
    int e;
    int c;
    int dt;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
    c = (tq.size() > 0) ? tq.pop_front() * 8 : 0;
    dt = int'(($realtime - t0) / 25.0);
    t0 = $realtime;
    check(e >= 0 && result_chan === e[17:16] && result_data === e[15:0], "result");
    check(dt >= c - 8 && dt <= c + 24, "conversion time");
    check(busy === (exp_q.size() > 0), "busy with strobe");
    check(ref_internal === 1'b1, "reference");
  end

  // ----------------------------------------------------------------
  // APB master and reference model
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Full-scale level saturates one code below the top; zero level is floor
  task automatic plan(input logic [3:0] mask);
    int h;
    int v;
    h = 1 << (res - 1);
    for (int ch = 0; ch < 4; ch++) if (mask[ch] && !(dif && ch == 1)) begin
      v = dif ? (level[0] ? h - 1 : -h) : (level[ch] ? h - 1 : 0);
      last_exp = ch * 65536 + (v & 16'hffff);
      exp_q.push_back(last_exp);
      tq.push_back(((ch != last) ? SETTLE_TICKS : 0) + (1 << res));
      last = ch;
    end
  endtask

  task automatic run(input logic [3:0] mask, input bit via_apb, input bit poke);
    logic [31:0] r;
    logic        e;
    int          n;
    level <= 4'($urandom());
    apb(1, CFG_OFF, {20'h0, 4'(res), 3'h0, dif, mask}, r, e);
    plan(mask);
    if (via_apb) apb(1, CTRL_OFF, 32'h1, r, e);
    else begin
      @(posedge pclk);
      converter_read_command <= 1;
      @(posedge pclk);
      converter_read_command <= 0;
    end
    t0 = $realtime;
    if (poke) begin
      repeat (40) @(posedge pclk);
      converter_read_command <= 1;
      apb(0, STATUS_OFF, 32'h0, r, e);
      converter_read_command <= 0;
      check(r[0] === 1'b1, "status busy");
    end
    n = 0;
    while ((busy !== 1'b0 || exp_q.size() > 0) && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    repeat (50) @(posedge pclk);
    check(busy === 1'b0 && exp_q.size() == 0, "sequence end");
    apb(0, RESULT_OFF, 32'h0, r, e);
    check(r[17:0] === last_exp[17:0], "result register");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    void'($urandom(48242));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, CFG_OFF, 32'h0, r, e);
    check(r === 32'({CFG_RES_RST, 4'h0, CFG_EN_RST}) && e === 1'b0, "cfg reset");
    apb(0, 8'h10, 32'h0, r, e);
    check(r === 32'h0 && e === 1'b1, "unmapped");
    apb(1, CFG_OFF, 32'h0301, r, e);
    apb(0, CFG_OFF, 32'h0, r, e);
    check(r[11:8] === 4'h7, "low clamp");
    apb(1, CFG_OFF, 32'h0f01, r, e);
    apb(0, CFG_OFF, 32'h0, r, e);
    check(r[11:8] === 4'hc, "high clamp");
    dif = 1;
    for (res = 7; res <= 12; res++) run(4'h3, res[0], 0);
    dif = 0;
    res = 7;
    run(4'he, 0, 1);
    run(4'hf, 1, 0);
    run(4'h9, 0, 0);
    complete_run();
  end
endmodule
